// ==== rtl/timer16_cc_pkg.sv ====
// Constants, register map and mode decoding for the 16-bit timer capture/compare block.
// Assumes an AXI4-Lite master with 32-bit data; every register uses the low byte only.
package timer16_cc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL_B = 8'h00;
	localparam logic [7:0] OFS_COMP_CSR = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
	localparam logic [7:0] OFS_CAP_LOW = 8'h10;
	localparam logic [7:0] OFS_CAP_HIGH = 8'h14;
	localparam logic [7:0] OFS_CMP_BASE = 8'h18;
	localparam logic [7:0] OFS_CMP_END = 8'h30;
	localparam logic [7:0] CMP_STRIDE = 8'h08;
	localparam logic [7:0] HIGH_STEP = 8'h04;
	localparam int CMP_CHANNELS = 3;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int BIT_FILTER_EN = 7;
	localparam int BIT_EDGE_SEL = 6;
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 3;
	localparam int BIT_CMP_SEL = 2;
	localparam int BIT_CAP = 0;
	localparam int CMP_FLAG_LSB = 1;
	localparam int HIGH_ADDR_BIT = 2;
	localparam logic [7:0] CTRL_B_MASK = 8'hCF;
	localparam logic [7:0] CTRL_B_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int FILTER_SAMPLES = 4;

	// ----------------------------------------------------------------
	// Waveform modes and fixed top values
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
	localparam logic [3:0] MODE_CTC_CAP = 4'hC;
	localparam logic [3:0] MODE_RESERVED = 4'hD;
	localparam logic [3:0] MODE_PFC_CAP = 4'h8;
	localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
	localparam logic [3:0] MODE_PC_CAP = 4'hA;
	localparam logic [3:0] MODE_PC_CMPA = 4'hB;
	localparam logic [3:0] MODE_FAST_CAP = 4'hE;
	localparam logic [3:0] MODE_FAST_CMPA = 4'hF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;

	// Modes that take the counter top from the capture register.
	function automatic logic uses_cap_top(input logic [3:0] m);
		return m inside {MODE_PFC_CAP, MODE_PC_CAP, MODE_CTC_CAP, MODE_FAST_CAP};
	endfunction

	// Modes that take the counter top from compare channel A.
	function automatic logic uses_cmpa_top(input logic [3:0] m);
		return m inside {MODE_CTC_CMPA, MODE_PFC_CMPA, MODE_PC_CMPA, MODE_FAST_CMPA};
	endfunction

	// Every mode other than normal, the two clear-on-match modes and the reserved one is PWM.
	function automatic logic is_pwm(input logic [3:0] m);
		return !(m inside {MODE_NORMAL, MODE_CTC_CMPA, MODE_CTC_CAP, MODE_RESERVED});
	endfunction

endpackage

// ==== rtl/capture_noise_filter.sv ====
// Four-sample majority-free noise filter in front of the capture edge detector.
// Assumes its input is already synchronised to aclk.
`timescale 1ns/10ps
module capture_noise_filter import timer16_cc_pkg::*; #(
	parameter int SAMPLES = FILTER_SAMPLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic sample_in,
	output logic filtered_out
);

	// ----------------------------------------------------------------
	// Sample history
	// ----------------------------------------------------------------
	logic [SAMPLES-1:0] samples;
	logic agree;

	assign agree = (&samples) || !(|samples);

	// The filter samples on every system clock, never on the prescaled tick.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			samples <= '0;
		end else begin
			samples <= {samples[SAMPLES-2:0], sample_in};
		end
	end

	// Bypassed, the output follows in one cycle; filtered, the oldest sample adds four more.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filtered_out <= 1'b0;
		end else if (!enable) begin
			filtered_out <= sample_in;
		end else if (agree) begin
			filtered_out <= samples[SAMPLES-1]; // [RULE9] [RULE10]
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	filter_hold_a: assert property (enable && !agree |=> $stable(filtered_out)) // [RULE9]
		else $error("Filter output moved without four agreeing samples.");
	filter_delay_a: assert property ($past(enable) && $changed(filtered_out)
		|-> filtered_out == $past(sample_in, 5)) // [RULE10]
		else $error("Filtered output change does not trail the input by five cycles.");

endmodule // capture_noise_filter

// ==== rtl/timer16_capture_compare.sv ====
// Input capture and output compare part of a 16-bit timer, with an AXI4-Lite register slave.
// Assumes the counter, prescaler and waveform generator sit outside and share aclk.
//
// Summary of operation
// [RULE1] A capture starts on a trigger edge of the selected polarity.
// [RULE2] A capture copies the counter into the capture register and sets the flag together.
// [RULE3] Capture flag requests interrupt when enabled; clears on interrupt or written one.
// [RULE4] Only the first timer may use the comparator output as trigger.
// [RULE5] A select bit in the comparator register picks comparator instead of pin.
// [RULE6] Software clears the capture flag after changing trigger source.
// [RULE7] Reading capture low byte loads its high byte into the shared latch.
// [RULE8] Capture register is writable only in capture-top modes, high byte first.
// [RULE9] The filter output changes only after four equal samples.
// [RULE10] An enabled filter adds exactly four clock cycles of latency.
// [RULE11] Filter enabled by a control B bit, sampled on the system clock.
// [RULE12] Filter and edge detector are inactive in capture-top modes.
// [RULE13] A new capture overwrites an unread capture value.
// [RULE14] Driving the capture pin from the port also makes a capture.
// [RULE15] Counter equal to a compare value sets its flag at the next timer tick.
// [RULE16] Compare flag requests interrupt when enabled; clears on interrupt or written one.
// [RULE17] Compare channel A can set the counter top value.
// [RULE18] Compare values are double-buffered in PWM modes, direct in other modes.
// [RULE19] Accesses go to the buffer when buffered, else to the active value.
// [RULE20] Compare values change only by writes and read without the latch.
// [RULE21] High byte goes to the latch; low write loads both bytes at once.
// [RULE22] One high-byte latch is shared by all registers of the timer.
// [RULE23] Edge select one picks rising edges, zero picks falling edges.
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module timer16_capture_compare import timer16_cc_pkg::*; #(
	parameter bit FIRST_TIMER = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [15:0] counter_value,
	input wire logic timer_tick,
	input wire logic count_top,
	input wire logic count_bottom,
	input wire logic capture_pin,
	input wire logic comparator_output,
	input wire logic capture_irq_ack,
	input wire logic [CMP_CHANNELS-1:0] compare_irq_ack,
	output logic [3:0] waveform_mode_select,
	output logic [15:0] counter_top,
	output logic [CMP_CHANNELS-1:0] compare_match,
	output logic capture_irq_req,
	output logic [CMP_CHANNELS-1:0] compare_irq_req
);

	// ----------------------------------------------------------------
	// Address helpers
	// ----------------------------------------------------------------
	function automatic logic cmp_addr(input logic [7:0] a, input int i, input logic hi);
		return a == OFS_CMP_BASE + 8'(i * CMP_STRIDE) + (hi ? HIGH_STEP : 8'h00);
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return (a < OFS_CMP_END) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic is_high(input logic [7:0] a);
		return a == OFS_CAP_HIGH ||
			(a >= OFS_CMP_BASE && a < OFS_CMP_END && a[HIGH_ADDR_BIT]);
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] ctrl_b;
	logic comparator_capture_select;
	logic [15:0] capture_register;
	logic [7:0] temp_byte;
	logic [15:0] cmp_active [CMP_CHANNELS];
	logic [15:0] cmp_buffer [CMP_CHANNELS];
	logic capture_flag;
	logic capture_irq_enable;
	logic [CMP_CHANNELS-1:0] compare_flag;
	logic [CMP_CHANNELS-1:0] compare_irq_enable;
	logic pin_s1, pin_s2, comp_s1, comp_s2;
	logic filt, filt_prev;
	logic [3:0] mode;
	logic pwm, reload, trigger, edge_hit, capture_evt, capture_clr;
	logic wr_go, rd_go, wr_en;
	logic [7:0] wr_byte;
	logic [7:0] read_byte;
	logic read_ok;
	logic [CMP_CHANNELS-1:0] cmp_wr, match, compare_clr;

	assign mode = ctrl_b[MODE_MSB:MODE_LSB];
	assign waveform_mode_select = mode;
	assign pwm = is_pwm(mode);
	assign wr_byte = wdata[7:0];
	assign wr_en = awready && wstrb[0];

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	// Address and data are taken together, one cycle after both are offered.
	assign wr_go = awvalid && wvalid && !awready && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			awready <= wr_go;
			wready <= wr_go;
			if (awready) begin
				bvalid <= 1'b1;
				bresp <= is_mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign rd_go = arvalid && !arready && !rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			arready <= rd_go;
			if (arready) begin
				rvalid <= 1'b1;
				rdata <= {24'h00_0000, read_byte};
				rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Read data; compare values bypass the shared latch, the capture high byte does not.
	always_comb begin
		read_byte = 8'h00;
		read_ok = is_mapped(araddr);
		case (araddr)
			OFS_CTRL_B: read_byte = ctrl_b;
			OFS_COMP_CSR: read_byte[BIT_CMP_SEL] = comparator_capture_select;
			OFS_FLAGS: begin
				read_byte[BIT_CAP] = capture_flag;
				read_byte[CMP_FLAG_LSB +: CMP_CHANNELS] = compare_flag;
			end
			OFS_IRQ_EN: begin
				read_byte[BIT_CAP] = capture_irq_enable;
				read_byte[CMP_FLAG_LSB +: CMP_CHANNELS] = compare_irq_enable;
			end
			OFS_CAP_LOW: read_byte = capture_register[7:0];
			OFS_CAP_HIGH: read_byte = temp_byte; // [RULE7]
			default: begin
				for (int i = 0; i < CMP_CHANNELS; i++) begin
					if (cmp_addr(araddr, i, 1'b0)) begin
						read_byte = pwm ? cmp_buffer[i][7:0] : cmp_active[i][7:0]; // [RULE19]
					end
					if (cmp_addr(araddr, i, 1'b1)) begin
						read_byte = pwm ? cmp_buffer[i][15:8] : cmp_active[i][15:8]; // [RULE20]
					end
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// The comparator select only exists on the first timer; elsewhere it stays zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_b <= CTRL_B_RESET;
			comparator_capture_select <= 1'b0;
			capture_irq_enable <= 1'b0;
			compare_irq_enable <= '0;
		end else if (wr_en) begin
			if (awaddr == OFS_CTRL_B) begin
				ctrl_b <= wr_byte & CTRL_B_MASK; // [RULE11]
			end
			if (awaddr == OFS_COMP_CSR) begin
				comparator_capture_select <= FIRST_TIMER && wr_byte[BIT_CMP_SEL]; // [RULE4]
			end
			if (awaddr == OFS_IRQ_EN) begin
				capture_irq_enable <= wr_byte[BIT_CAP];
				compare_irq_enable <= wr_byte[CMP_FLAG_LSB +: CMP_CHANNELS];
			end
		end
	end

	// ----------------------------------------------------------------
	// Shared high-byte latch
	// ----------------------------------------------------------------
	// A high-byte write wins over a simultaneous capture low-byte read.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			temp_byte <= 8'h00;
		end else if (wr_en && is_high(awaddr)) begin
			temp_byte <= wr_byte; // [RULE22] [RULE21]
		end else if (arready && araddr == OFS_CAP_LOW) begin
			temp_byte <= capture_register[15:8]; // [RULE7]
		end
	end

	// ----------------------------------------------------------------
	// Capture trigger path
	// ----------------------------------------------------------------
	// Two flops per asynchronous source; a port-driven pin level enters the same way.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			comp_s1 <= 1'b0;
			comp_s2 <= 1'b0;
		end else begin
			pin_s1 <= capture_pin; // [RULE14]
			pin_s2 <= pin_s1;
			comp_s1 <= comparator_output;
			comp_s2 <= comp_s1;
		end
	end

	// Switching source can itself look like an edge; software clears the flag afterwards.
	assign trigger = comparator_capture_select ? comp_s2 : pin_s2; // [RULE5] [RULE6]

	capture_noise_filter #(
		.SAMPLES(FILTER_SAMPLES)
	) u_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(ctrl_b[BIT_FILTER_EN]),
		.sample_in(trigger),
		.filtered_out(filt)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filt_prev <= 1'b0;
		end else begin
			filt_prev <= filt;
		end
	end

	// Edge detector; in capture-top modes the capture register is the top and must not move.
	assign edge_hit = (filt != filt_prev) && (filt == ctrl_b[BIT_EDGE_SEL]); // [RULE1] [RULE23]
	assign capture_evt = edge_hit && !uses_cap_top(mode); // [RULE12]

	// Capture stamp; an unread value is simply overwritten.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_register <= 16'h0000;
		end else if (capture_evt) begin
			capture_register <= counter_value; // [RULE2] [RULE13]
		end else if (wr_en && awaddr == OFS_CAP_LOW && uses_cap_top(mode)) begin
			capture_register <= {temp_byte, wr_byte}; // [RULE8]
		end
	end

	// ----------------------------------------------------------------
	// Flags and interrupt requests
	// ----------------------------------------------------------------
	assign capture_clr = (wr_en && awaddr == OFS_FLAGS && wr_byte[BIT_CAP]) || capture_irq_ack;
	assign compare_clr = ({CMP_CHANNELS{wr_en && awaddr == OFS_FLAGS}}
		& wr_byte[CMP_FLAG_LSB +: CMP_CHANNELS]) | compare_irq_ack;

	// A set in the same cycle as a clear wins, so no event is lost.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_flag <= 1'b0;
			compare_flag <= '0;
		end else begin
			capture_flag <= capture_evt || (capture_flag && !capture_clr); // [RULE2] [RULE3]
			compare_flag <= ({CMP_CHANNELS{timer_tick}} & match)
				| (compare_flag & ~compare_clr); // [RULE15] [RULE16]
		end
	end

	// Requests trail the flags by one cycle so that every output comes from a flop.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_irq_req <= 1'b0;
			compare_irq_req <= '0;
		end else begin
			capture_irq_req <= capture_flag && capture_irq_enable; // [RULE3]
			compare_irq_req <= compare_flag & compare_irq_enable; // [RULE16]
		end
	end

	// ----------------------------------------------------------------
	// Compare channels
	// ----------------------------------------------------------------
	// Fast and phase correct modes reload at top, phase-and-frequency correct at bottom.
	assign reload = (mode == MODE_PFC_CAP || mode == MODE_PFC_CMPA) ? count_bottom : count_top;

	always_comb begin
		for (int i = 0; i < CMP_CHANNELS; i++) begin
			cmp_wr[i] = wr_en && cmp_addr(awaddr, i, 1'b0);
			match[i] = counter_value == cmp_active[i];
		end
	end

	// Only bus writes change these values; the counter never writes them back.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < CMP_CHANNELS; i++) begin
				cmp_active[i] <= 16'h0000;
				cmp_buffer[i] <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < CMP_CHANNELS; i++) begin
				if (cmp_wr[i]) begin
					cmp_buffer[i] <= {temp_byte, wr_byte}; // [RULE21] [RULE20]
				end
				if (cmp_wr[i] && !pwm) begin
					cmp_active[i] <= {temp_byte, wr_byte}; // [RULE19]
				end else if (pwm && reload) begin
					cmp_active[i] <= cmp_buffer[i]; // [RULE18]
				end
			end
		end
	end

	// Match pulses for the waveform generator, one per timer tick.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			compare_match <= '0;
		end else begin
			compare_match <= {CMP_CHANNELS{timer_tick}} & match; // [RULE15]
		end
	end

	// Top value offered to the counter.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter_top <= TOP_MAX;
		end else if (uses_cap_top(mode)) begin
			counter_top <= capture_register;
		end else if (uses_cmpa_top(mode)) begin
			counter_top <= cmp_active[0]; // [RULE17]
		end else begin
			case (mode)
				4'h1, 4'h5: counter_top <= TOP_8BIT;
				4'h2, 4'h6: counter_top <= TOP_9BIT;
				4'h3, 4'h7: counter_top <= TOP_10BIT;
				default: counter_top <= TOP_MAX;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	capture_stamp_a: assert property (capture_evt
		|=> capture_register == $past(counter_value) && capture_flag) // [RULE2]
		else $error("Capture did not stamp the counter with its flag.");
	capture_edge_a: assert property (capture_evt
		|-> $changed(filt) && ($rose(filt) == ctrl_b[BIT_EDGE_SEL])) // [RULE1]
		else $error("Capture without a matching edge.");
	capture_block_a: assert property (uses_cap_top(mode) |-> !capture_evt) // [RULE12]
		else $error("Capture taken in a capture-top mode.");
	flag_clear_a: assert property (capture_irq_ack && !capture_evt |=> !capture_flag) // [RULE3]
		else $error("Capture flag survived its acknowledge.");
	source_sel_a: assert property (!FIRST_TIMER |-> !comparator_capture_select) // [RULE4]
		else $error("Comparator source selected on a later timer.");
	latch_load_a: assert property (arready && araddr == OFS_CAP_LOW && !wr_en
		|=> temp_byte == $past(capture_register[15:8])) // [RULE7]
		else $error("Capture high byte not latched on low read.");
	compare_flag_a: assert property (timer_tick && match[0]
		|=> compare_flag[0] && compare_match[0]) // [RULE15]
		else $error("Compare match did not set the flag.");
	compare_buffer_a: assert property (pwm && cmp_wr[0] && !reload
		|=> $stable(cmp_active[0])) // [RULE18]
		else $error("Buffered compare value changed before reload.");
	compare_direct_a: assert property (!pwm && cmp_wr[0]
		|=> cmp_active[0] == {$past(temp_byte), $past(wdata[7:0])}) // [RULE21]
		else $error("Direct compare write lost a byte.");
	cmpa_top_a: assert property (uses_cmpa_top(mode) ##1 uses_cmpa_top(mode)
		|-> counter_top == $past(cmp_active[0])) // [RULE17]
		else $error("Top value not taken from channel A.");

	capture_seen_c: cover property (capture_evt ##[1:20] arready && araddr == OFS_CAP_LOW);
	compare_seen_c: cover property (timer_tick && match[1]);
	reload_seen_c: cover property (pwm && cmp_wr[2] ##[1:50] reload);
	clear_race_c: cover property (capture_evt && capture_clr);

endmodule // timer16_capture_compare

// ==== test/cpu_bus_model.sv ====
// AXI4-Lite master standing in for the CPU core, one byte register per call.
// Assumes the slave runs on aclk; bready and rready simply stay high.
`timescale 1ns/10ps
module cpu_bus_model import timer16_cc_pkg::*; (
	input wire logic aclk,
	output logic [ADDR_W-1:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [ADDR_W-1:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// Idle bus; answers are always accepted, so no release races between calls.
	initial begin
		{awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
		wstrb = 4'h1;
		{bready, rready} = 2'h3;
	end
	// Address and data go out together and are held until taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (!bvalid);
		r = bresp;
	endtask
	// Read data and response are taken at the edge that shows rvalid.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata[7:0];
		r = rresp;
	endtask
endmodule // cpu_bus_model

// ==== test/test_timer16_capture_compare.sv ====
// Self-checking bench for the timer capture/compare block.
// Assumes the package register map; the counter side is driven here.
`timescale 1ns/10ps
module test_timer16_capture_compare import timer16_cc_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, waveform_mode_select;
	logic [1:0] bresp, rresp, rs;
	logic [15:0] counter_value = 16'h0000, counter_top, cv, ca;
	logic timer_tick = 1'b0, count_top = 1'b0, count_bottom = 1'b0, capture_pin = 1'b0;
	logic comparator_output = 1'b0, capture_irq_ack = 1'b0, capture_irq_req;
	logic [CMP_CHANNELS-1:0] compare_irq_ack = '0, compare_match, compare_irq_req;
	logic [7:0] rv, lo;
	int n_mismatch = 0, n_tests = 0, seed = 65776, k, k0;
	// Clock of 25 ns period.
	always #12.5 aclk = ~aclk;
	// Design and bus master meet on signals of the same names.
	timer16_capture_compare timer16_capture_compare_inst (.*);
	cpu_bus_model cpu_bus_model_inst (.*);
	// Count a comparison and report a mismatch at once.
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic w8(input logic [7:0] a, input logic [7:0] d);
		cpu_bus_model_inst.wr(a, d, rs);
	endtask
	task automatic r8(input logic [7:0] a);
		cpu_bus_model_inst.rd(a, rv, rs);
	endtask
	// High byte first, so the shared latch holds it when the low byte lands.
	task automatic w16(input logic [7:0] a, input logic [15:0] v);
		w8(a + HIGH_STEP, v[15:8]);
		w8(a, v[7:0]);
	endtask
	// Low byte first; the high byte is left in rv.
	task automatic r16(input logic [7:0] a);
		r8(a);
		lo = rv;
		r8(a + HIGH_STEP);
	endtask
	function automatic logic [7:0] cmp_lo(input int c);
		return OFS_CMP_BASE + 8'(c) * CMP_STRIDE;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Single exit: counts, then the verdict.
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Main sequence; the filter latency is measured relative to the unfiltered path.
	initial begin
		tick(10);
		aresetn <= 1'b1;
		tick(1);
		chk("top_rst", TOP_MAX, counter_top);
		w8(OFS_IRQ_EN, 8'h0F);
		for (int i = 0; i < 4; i++) begin
			w8(OFS_CTRL_B, {i[1], i[0], 6'h00});
			capture_pin <= !i[0];
			tick(12);
			w8(OFS_FLAGS, 8'h01);
			cv = 16'($random(seed));
			counter_value <= cv;
			capture_pin <= i[0];
			k = 0;
			while (capture_irq_req !== 1'b1 && k < 30) begin
				tick(1);
				k++;
			end
			if (i == 0) k0 = k;
			chk("cap_lat", 16'(k0 + 4 * i[1]), 16'(k));
			counter_value <= ~cv;
			r16(OFS_CAP_LOW);
			chk("cap_val", cv, {rv, lo});
			capture_irq_ack <= 1'b1;
			tick(1);
			capture_irq_ack <= 1'b0;
			tick(3);
			chk("cap_ack", '0, capture_irq_req);
		end
		r8(OFS_CAP_LOW);
		w8(cmp_lo(1) + HIGH_STEP, 8'hA5);
		r8(OFS_CAP_HIGH);
		chk("latch", 16'h00A5, rv);
		// A three-cycle pulse must not pass the filter.
		capture_pin <= 1'b0;
		tick(12);
		w8(OFS_FLAGS, 8'h01);
		capture_pin <= 1'b1;
		tick(3);
		capture_pin <= 1'b0;
		tick(12);
		chk("glitch", '0, capture_irq_req);
		w8(OFS_CTRL_B, 8'h40);
		w8(OFS_COMP_CSR, 8'h04);
		w8(OFS_FLAGS, 8'h01);
		comparator_output <= 1'b1;
		tick(12);
		chk("cmp_src", 16'h0001, capture_irq_req);
		w8(OFS_CTRL_B, {4'h4, MODE_CTC_CAP});
		chk("mode", 16'(MODE_CTC_CAP), 16'(waveform_mode_select));
		w8(OFS_COMP_CSR, 8'h00);
		cv = 16'($random(seed));
		w16(OFS_CAP_LOW, cv);
		w8(OFS_FLAGS, 8'h01);
		capture_pin <= 1'b1;
		tick(12);
		chk("cap_top", cv, counter_top);
		chk("cap_blk", '0, capture_irq_req);
		w8(OFS_CTRL_B, 8'h00);
		for (int c = 0; c < CMP_CHANNELS; c++) begin
			cv = 16'($random(seed));
			if (c == 0) ca = cv;
			w16(cmp_lo(c), cv);
			r16(cmp_lo(c));
			chk("cmp_rd", cv, {rv, lo});
			counter_value <= cv;
			timer_tick <= 1'b1;
			tick(1);
			timer_tick <= 1'b0;
			tick(1);
			chk("cmp_match", 16'(1 << c), 16'(compare_match));
			tick(2);
			chk("cmp_irq", 16'(1 << c), compare_irq_req);
			compare_irq_ack[c] <= 1'b1;
			tick(1);
			compare_irq_ack <= '0;
			tick(2);
			chk("cmp_ack", '0, compare_irq_req);
		end
		w8(OFS_CTRL_B, {4'h0, MODE_FAST_CMPA});
		tick(2);
		chk("top_a", ca, counter_top);
		w16(cmp_lo(0), ~ca);
		tick(2);
		chk("buf_hold", ca, counter_top);
		count_top <= 1'b1;
		tick(1);
		count_top <= 1'b0;
		tick(3);
		chk("buf_load", ~ca, counter_top);
		r8(OFS_CMP_END);
		chk("unmapped", RESP_SLVERR, rs);
		w8(OFS_CMP_END, 8'h5A);
		chk("unmapped_wr", RESP_SLVERR, rs);
		w8(OFS_CTRL_B, 8'h00);
		chk("mapped_wr", RESP_OKAY, rs);
		results();
	end
	// Watchdog, well beyond the expected run of a few hundred cycles.
	initial begin
		tick(20000);
		n_mismatch++;
		results();
	end
endmodule // test_timer16_capture_compare
